//--- src/sss_pkg.sv
/*
 soft start sequencer package: codes, step counts, soft-start timing and reference scaling.
 assumes a 40 MHz clock and a digital reference code in units of 0.5 mV.
*/
package sss_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam real SS_TIME_MS = 2.0;
   // cycles for the whole ramp, rounded to the nearest cycle by the int cast
   localparam int SS_CYCLES = int'(SS_TIME_MS * 1.0e-3 * CLK_HZ);
   localparam int SS_STEPS = 15;
   localparam int STEP_CYCLES = SS_CYCLES / SS_STEPS;
   // reference code width; one lsb is 0.5 mV, full scale 150 mV = 300 codes
   localparam int REF_W = 10;
   localparam logic [9:0] REF_FULL = 10'h12C;
   localparam logic [9:0] EXT_MIN = 10'h03F;
   // extension reference is 0.8 x reference = 4/5
   localparam int EXT_NUM = 4;
   localparam int EXT_DEN = 5;
   localparam int EARLY_STEPS = 3;
   localparam real VLOOP_REF_V = 1.6;
   // duty limits in percent, per switching mode
   localparam logic [6:0] DMAX_ADJ = 7'h5B;
   localparam logic [6:0] DMAX_LF = 7'h58;
   localparam logic [6:0] DMAX_HF = 7'h50;
   localparam logic [1:0] MODE_ADJ = 2'h0;
   localparam logic [1:0] MODE_LF = 2'h1;
   localparam logic [1:0] MODE_HF = 2'h2;
   typedef enum logic [2:0] {
      SSS_IDLE = 3'b001,
      SSS_RAMP = 3'b010,
      SSS_DONE = 3'b100
   } sss_state_e;
endpackage

//--- src/sss_sequencer.sv
/*
 soft start sequencer: ramps the current-loop reference code, computes the extension
 reference, stretches dimming on-times and selects the regulating loop.
 assumes comparator and fault inputs arrive asynchronously from the analog side; the
 analog loop turns the reference code and duty limit into switching.
*/
// Summary of operation
// - first dimming rising edge or first internal pwm cycle arms soft start.
// - soft start runs at start-up and after overvoltage, overtemperature, supply undervoltage.
// - short to ground starts soft start, retriggered every fault retry period.
// - without adjustment reference rises zero to full scale in 15 steps over 2 ms.
// - with adjustment the lowered target is reached early then held.
// - extend on pulse when shorter than soft start and sense below extension reference.
// - extension continues until sensed voltage reaches extension reference.
// - extension reference is 0.8 of reference, floored at 31.5 mV.
// - first three ramp steps keep extension reference above the reference.
// - with target below the floor, extension ends when soft-start time expires.
// - extension ending early is retriggered next pwm cycle if sense is low again.
// - after an extension, the ramp advances only during dimming on times.
// - current loop always active; voltage loop only when configured.
// - voltage loop takes over once feedback reaches its 1.6 V reference.
// - duty limit 91, 88 or 80 percent by switching mode.
`timescale 1ns/1ps
`default_nettype none
module sss_sequencer #(
   parameter int SS_CYCLES = sss_pkg::SS_CYCLES,
   parameter int FAULT_RETRY_CYCLES = 400000
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic dimming_input,
   input wire logic internal_pwm_cycle,
   input wire logic use_internal_pwm,
   input wire logic fault_sense_high_ov,
   input wire logic fault_voltage_feedback_ov,
   input wire logic fault_overtemp,
   input wire logic fault_internal_supply_uv,
   input wire logic fault_short_to_ground,
   input wire logic [9:0] adjust_target,
   input wire logic sense_below_ext,
   input wire logic feedback_at_ref,
   input wire logic voltage_loop_enable,
   input wire logic [1:0] switch_mode,
   output logic [9:0] current_reference,
   output logic [9:0] extension_reference,
   output logic gate_enable,
   output logic soft_start_active,
   output logic voltage_loop_active,
   output logic [6:0] duty_limit
);
   ////////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   localparam int NS = 9;
   logic [NS-1:0] raw, s1_q, s2_q, s3_q;
   assign raw = {dimming_input, internal_pwm_cycle, fault_sense_high_ov,
                 fault_voltage_feedback_ov, fault_overtemp, fault_internal_supply_uv,
                 fault_short_to_ground, sense_below_ext, feedback_at_ref};
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   logic dim_s, pwm_s, sense_low, fb_ref, stg;
   logic dim_rise, pwm_rise, fault_rise, on_time, on_fall;
   assign dim_s = s2_q[8];
   assign pwm_s = s2_q[7];
   assign stg = s2_q[2];
   assign sense_low = s2_q[1];
   assign fb_ref = s2_q[0];
   assign dim_rise = dim_s && !s3_q[8];
   assign pwm_rise = pwm_s && !s3_q[7];
   // any new fault edge restarts the ramp once soft start is armed
   assign fault_rise = |(s2_q[6:2] & ~s3_q[6:2]);
   assign on_time = use_internal_pwm ? pwm_s : dim_s;
   assign on_fall = use_internal_pwm ? (!pwm_s && s3_q[7]) : (!dim_s && s3_q[8]);

   ////////////////////////////////////////////////////////////////////////////////
   // arming and triggers
   logic armed_q, trig;
   logic [19:0] retry_q;
   logic retry_hit;
   assign retry_hit = stg && (retry_q == 20'(FAULT_RETRY_CYCLES - 1));
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         armed_q <= 1'b0;
      end else if (use_internal_pwm ? pwm_rise : dim_rise) begin
         armed_q <= 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst || !stg || retry_hit) begin
         retry_q <= 20'h00000;
      end else begin
         retry_q <= retry_q + 20'h00001;
      end
   end
   // first arming edge is the start-up case
   assign trig = (!armed_q && (use_internal_pwm ? pwm_rise : dim_rise))
                 || (armed_q && (fault_rise || retry_hit));

   ////////////////////////////////////////////////////////////////////////////////
   // ramp state
   sss_pkg::sss_state_e state_q;
   logic [3:0] step_q;
   logic [21:0] ss_cnt_q;
   logic ext_q, ext_seen_q, ss_expired, step_pulse, step_run;
   assign ss_expired = (ss_cnt_q >= 22'(SS_CYCLES));
   // after an extension, time only flows during on times
   assign step_run = (state_q == sss_pkg::SSS_RAMP) && (!ext_seen_q || on_time || ext_q);
   sss_step_timer #(.STEP_CYCLES(sss_pkg::STEP_CYCLES)) u_timer (
      .clock(clock),
      .sys_rst(sys_rst),
      .restart(trig),
      .run(step_run),
      .step_pulse(step_pulse)
   );
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= sss_pkg::SSS_IDLE;
         step_q <= 4'h0;
      end else if (trig) begin
         state_q <= sss_pkg::SSS_RAMP;
         step_q <= 4'h0;
      end else begin
         case (state_q)
            sss_pkg::SSS_IDLE: state_q <= sss_pkg::SSS_IDLE;
            sss_pkg::SSS_RAMP: begin
               if (step_pulse) begin
                  step_q <= step_q + 4'h1;
                  if (step_q == 4'(sss_pkg::SS_STEPS - 1)) begin
                     state_q <= sss_pkg::SSS_DONE;
                  end
               end
            end
            sss_pkg::SSS_DONE: state_q <= sss_pkg::SSS_DONE;
            default: state_q <= sss_pkg::SSS_IDLE;
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst || trig) begin
         ss_cnt_q <= 22'h000000;
      end else if (state_q == sss_pkg::SSS_RAMP && !ss_expired) begin
         ss_cnt_q <= ss_cnt_q + 22'h000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reference arithmetic
   function automatic logic [9:0] ramp_ref(input logic [3:0] n);
      logic [13:0] p;
      p = 14'(n) * 14'(sss_pkg::REF_FULL);
      return 10'(p / 14'(sss_pkg::SS_STEPS));
   endfunction
   logic [9:0] ramp_val, ref_d, ext_d, target;
   logic [11:0] ext_scaled;
   assign target = (adjust_target > sss_pkg::REF_FULL) ? sss_pkg::REF_FULL : adjust_target;
   assign ramp_val = ramp_ref(step_q);
   always_comb begin
      ref_d = (state_q == sss_pkg::SSS_DONE) ? target : ramp_val;
      if (ref_d > target) begin
         ref_d = target;
      end
      if (state_q == sss_pkg::SSS_IDLE) begin
         ref_d = 10'h000;
      end
      ext_scaled = (12'(ref_d) * 12'(sss_pkg::EXT_NUM)) / 12'(sss_pkg::EXT_DEN);
      ext_d = ext_scaled[9:0];
      if (ext_d < sss_pkg::EXT_MIN) begin
         ext_d = sss_pkg::EXT_MIN;
      end
      // early steps: floor lifts the extension reference over the ramp
      if (state_q == sss_pkg::SSS_RAMP && step_q < 4'(sss_pkg::EARLY_STEPS)
          && ext_d <= ref_d) begin
         ext_d = ref_d + 10'h001;
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         current_reference <= 10'h000;
         extension_reference <= sss_pkg::EXT_MIN;
      end else begin
         current_reference <= ref_d;
         extension_reference <= ext_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // on time extension
   logic low_target, ext_end, ext_start;
   assign low_target = (target < sss_pkg::EXT_MIN);
   assign ext_end = !sense_low || (low_target && ss_expired);
   // on pulse ended inside soft start, so it was shorter than the ramp
   assign ext_start = !ext_q && on_fall && (state_q == sss_pkg::SSS_RAMP) && !ss_expired
                      && sense_low;
   always_ff @(posedge clock) begin
      if (sys_rst || trig) begin
         ext_q <= 1'b0;
      end else if (ext_q) begin
         if (ext_end) begin
            ext_q <= 1'b0;
         end
      end else if (ext_start) begin
         ext_q <= 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst || trig) begin
         ext_seen_q <= 1'b0;
      end else if (ext_q && ext_end) begin
         ext_seen_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // loop selection and duty limit
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         gate_enable <= 1'b0;
         soft_start_active <= 1'b0;
         voltage_loop_active <= 1'b0;
         duty_limit <= sss_pkg::DMAX_ADJ;
      end else begin
         // ext_start bridges the hand-over so the gate never drops between pulse and extension
         gate_enable <= armed_q && (on_time || ext_q || ext_start);
         soft_start_active <= (state_q == sss_pkg::SSS_RAMP);
         // current loop stays on; this only hands regulation over
         voltage_loop_active <= voltage_loop_enable && fb_ref;
         case (switch_mode)
            sss_pkg::MODE_ADJ: duty_limit <= sss_pkg::DMAX_ADJ;
            sss_pkg::MODE_LF: duty_limit <= sss_pkg::DMAX_LF;
            sss_pkg::MODE_HF: duty_limit <= sss_pkg::DMAX_HF;
            default: duty_limit <= sss_pkg::DMAX_HF;
         endcase
      end
   end
endmodule // sss_sequencer
`default_nettype wire

//--- src/sss_step_timer.sv
/*
 step timer: counts cycles while enabled and pulses at each step boundary.
 assumes a single clock; restart clears the count in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module sss_step_timer #(
   parameter int STEP_CYCLES = 5333
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic restart,
   input wire logic run,
   output logic step_pulse
);
   logic [15:0] cnt_q;
   always_ff @(posedge clock) begin
      if (sys_rst || restart) begin
         cnt_q <= 16'h0000;
         step_pulse <= 1'b0;
      end else if (run) begin
         if (cnt_q == 16'(STEP_CYCLES - 1)) begin
            cnt_q <= 16'h0000;
            step_pulse <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
            step_pulse <= 1'b0;
         end
      end else begin
         step_pulse <= 1'b0;
      end
   end
endmodule // sss_step_timer
`default_nettype wire

//--- testbench/soft_start_sequencer_tb.sv
/* self-checking bench for the sequencer and the analog model.
 assumes 40 MHz clock and the package step length. */
`timescale 1ns/1ps
`default_nettype none
module soft_start_sequencer_tb;
   typedef struct {logic [2:0] sel; logic [9:0] val;} sss_note_s;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic dimming_input = 1'b0;
   logic use_internal_pwm = 1'b0;
   logic internal_pwm_cycle = 1'b0;
   logic [4:0] faults = 5'h00;
   logic [9:0] adjust_target = 10'h12C;
   logic voltage_loop_enable = 1'b1;
   logic [1:0] switch_mode = 2'h0;
   logic [15:0] fill = 16'h0032;
   logic sense_below_ext, feedback_at_ref, gate_enable, soft_start_active, voltage_loop_active;
   logic [9:0] current_reference, extension_reference;
   logic [6:0] duty_limit;
   sss_note_s exp_q[$];
   sss_note_s e;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int k, src;
   localparam int STEP = sss_pkg::STEP_CYCLES;
   always #12.5 clock = ~clock;
   sss_sequencer uut (.clock(clock), .sys_rst(sys_rst), .dimming_input(dimming_input),
      .internal_pwm_cycle(internal_pwm_cycle), .use_internal_pwm(use_internal_pwm),
      .fault_sense_high_ov(faults[0]),
      .fault_voltage_feedback_ov(faults[1]), .fault_overtemp(faults[2]),
      .fault_internal_supply_uv(faults[3]), .fault_short_to_ground(faults[4]),
      .adjust_target(adjust_target), .sense_below_ext(sense_below_ext),
      .feedback_at_ref(feedback_at_ref), .voltage_loop_enable(voltage_loop_enable),
      .switch_mode(switch_mode), .current_reference(current_reference),
      .extension_reference(extension_reference), .gate_enable(gate_enable),
      .soft_start_active(soft_start_active), .voltage_loop_active(voltage_loop_active),
      .duty_limit(duty_limit));
   sss_analog_model u_model (.clock(clock), .sys_rst(sys_rst), .gate_enable(gate_enable),
      .fill(fill), .sense_below_ext(sense_below_ext), .feedback_at_ref(feedback_at_ref));
   ////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic note(input logic [2:0] sel, input logic [9:0] val);
      exp_q.push_back('{sel, val});
   endtask
   task automatic check(input logic [9:0] seen, input logic [9:0] want);
      tests_run++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic final_report;
      if (n_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // notes are judged half a cycle later, once every output has settled
   always @(negedge clock) begin
      while (exp_q.size() != 0) begin
         e = exp_q.pop_front();
         case (e.sel)
            3'h0: check(current_reference, e.val);
            3'h1: check({9'h000, gate_enable}, e.val);
            3'h2: check({9'h000, soft_start_active}, e.val);
            3'h3: check({9'h000, voltage_loop_active}, e.val);
            3'h5: check(extension_reference, e.val);
            default: check({3'h0, duty_limit}, e.val);
         endcase
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 99000) begin
         n_errors++;
         final_report();
      end
   end
   ////////////////////////////////
   initial begin
      void'($urandom(60025));
      cyc(12);
      sys_rst <= 1'b0;
      cyc(5);
      faults <= 5'h1F;
      cyc(20);
      note(3'h2, 10'h000);
      faults <= 5'h00;
      dimming_input <= 1'b1;
      cyc(100);
      note(3'h2, 10'h001);
      note(3'h0, 10'h000);
      note(3'h3, 10'h000);
      note(3'h5, sss_pkg::EXT_MIN);
      dimming_input <= 1'b0;
      cyc(20);
      note(3'h1, 10'h000);
      cyc(20);
      // slow loop: a short pulse ends with the sensed voltage still low
      fill <= 16'h00C8;
      dimming_input <= 1'b1;
      cyc(20);
      dimming_input <= 1'b0;
      cyc(80);
      note(3'h1, 10'h001);
      cyc(160);
      note(3'h1, 10'h000);
      cyc(6000);
      note(3'h0, 10'h000);
      dimming_input <= 1'b1;
      cyc(STEP);
      note(3'h0, 10'h014);
      src = $urandom % 5;
      faults <= 5'h01 << src;
      cyc(STEP / 2);
      for (k = 0; k < 15; k++) begin
         note(3'h0, 10'(k * 20));
         if (k == 7) note(3'h3, 10'h001);
         cyc(STEP);
      end
      note(3'h0, sss_pkg::REF_FULL);
      note(3'h5, 10'h0F0);
      note(3'h2, 10'h000);
      faults <= 5'h00;
      adjust_target <= 10'h064;
      cyc(10);
      note(3'h0, 10'h064);
      note(3'h5, 10'h050);
      for (k = 0; k < 8; k++) begin
         switch_mode <= 2'($urandom);
         voltage_loop_enable <= 1'($urandom);
         cyc(8);
         note(3'h4, switch_mode == 2'h0 ? 10'h05B : switch_mode == 2'h1 ? 10'h058 : 10'h050);
         note(3'h3, {9'h000, voltage_loop_enable});
      end
      // mid-run reset, then arm from the internal engine while the dimming pin stays high
      use_internal_pwm <= 1'b1;
      sys_rst <= 1'b1;
      cyc(3);
      sys_rst <= 1'b0;
      cyc(10);
      note(3'h2, 10'h000);
      note(3'h1, 10'h000);
      internal_pwm_cycle <= 1'b1;
      cyc(10);
      note(3'h2, 10'h001);
      note(3'h1, 10'h001);
      final_report();
   end
endmodule // soft_start_sequencer_tb
`default_nettype wire

//--- testbench/sss_analog_model.sv
/* analog side: sensed voltage climbs while the gate is on.
 assumes fill is set by the bench. */
`timescale 1ns/1ps
`default_nettype none
module sss_analog_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic gate_enable,
   input wire logic [15:0] fill,
   output logic sense_below_ext,
   output logic feedback_at_ref
);
   logic [15:0] charge_q;
   // output discharges when the gate is off, so each on time starts low
   always_ff @(posedge clock) begin
      if (sys_rst || !gate_enable) charge_q <= 16'h0000;
      else if (charge_q != 16'hFFFF) charge_q <= charge_q + 16'h0001;
   end
   assign sense_below_ext = charge_q < fill;
   assign feedback_at_ref = charge_q >= 16'h0400;
endmodule // sss_analog_model
`default_nettype wire

//--- testbench/sss_props.sv
/* port checker for the sequencer.
 assumes it is bound onto sss_sequencer, one clock. */
`timescale 1ns/1ps
`default_nettype none
module sss_props (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic fault_sense_high_ov,
   input wire logic fault_voltage_feedback_ov,
   input wire logic fault_overtemp,
   input wire logic fault_internal_supply_uv,
   input wire logic fault_short_to_ground,
   input wire logic [9:0] adjust_target,
   input wire logic voltage_loop_enable,
   input wire logic [1:0] switch_mode,
   input wire logic [9:0] current_reference,
   input wire logic [9:0] extension_reference,
   input wire logic gate_enable,
   input wire logic soft_start_active,
   input wire logic voltage_loop_active,
   input wire logic [6:0] duty_limit
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic seen_q;
   logic [11:0] scaled;
   logic [9:0] ext_exp;
   logic [6:0] duty_exp;
   wire fault_any = fault_sense_high_ov | fault_voltage_feedback_ov | fault_overtemp
      | fault_internal_supply_uv | fault_short_to_ground;
   assign scaled = {2'h0, current_reference} * 12'h004 / 12'h005;
   assign ext_exp = (scaled[9:0] < sss_pkg::EXT_MIN) ? sss_pkg::EXT_MIN : scaled[9:0];
   assign duty_exp = (switch_mode == 2'h0) ? 7'h5B : (switch_mode == 2'h1) ? 7'h58 : 7'h50;
   // faults only count once soft start has been active
   always_ff @(posedge clock) begin
      if (sys_rst) seen_q <= 1'b0;
      else if (soft_start_active) seen_q <= 1'b1;
   end
   ////////////////////////////////
   sequence s_restarted;
      soft_start_active && current_reference == 10'h000;
   endsequence
   property p_reset_vals;
      $past(sys_rst) |-> current_reference == 10'h000 && !gate_enable
         && extension_reference == sss_pkg::EXT_MIN && duty_limit == sss_pkg::DMAX_ADJ;
   endproperty
   property p_duty;
      1'b1 |=> duty_limit == $past(duty_exp);
   endproperty
   property p_floor;
      extension_reference >= sss_pkg::EXT_MIN;
   endproperty
   // ref held two cycles so a one-cycle lag of the scaling does not matter
   property p_scale;
      $stable(current_reference) && current_reference == $past(current_reference, 2)
         && current_reference >= 10'h03C |-> extension_reference == ext_exp;
   endproperty
   property p_early;
      soft_start_active && current_reference < 10'h03C |-> extension_reference > current_reference;
   endproperty
   property p_ref_max;
      current_reference <= sss_pkg::REF_FULL;
   endproperty
   property p_target;
      $stable(adjust_target) && $past(adjust_target, 2) == adjust_target
         |-> current_reference <= adjust_target;
   endproperty
   property p_restart;
      seen_q && $rose(fault_any) |-> ##[1:8] s_restarted;
   endproperty
   property p_vloop;
      !voltage_loop_enable |=> !voltage_loop_active;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("outputs not at reset values");
   a_duty: assert property (p_duty)
      else $error("duty limit does not follow mode");
   a_floor: assert property (p_floor)
      else $error("extension reference below floor");
   a_scale: assert property (p_scale)
      else $error("extension reference not four fifths");
   a_early: assert property (p_early)
      else $error("extension reference not above reference");
   a_ref_max: assert property (p_ref_max)
      else $error("reference above full scale");
   a_target: assert property (p_target)
      else $error("reference above adjusted target");
   a_restart: assert property (p_restart)
      else $error("fault did not restart the ramp");
   a_vloop: assert property (p_vloop)
      else $error("voltage loop active while disabled");
endmodule // sss_props
bind sss_sequencer sss_props u_props (.clock, .sys_rst, .fault_sense_high_ov,
   .fault_voltage_feedback_ov, .fault_overtemp, .fault_internal_supply_uv,
   .fault_short_to_ground, .adjust_target, .voltage_loop_enable, .switch_mode,
   .current_reference, .extension_reference, .gate_enable, .soft_start_active,
   .voltage_loop_active, .duty_limit);
`default_nettype wire
